// ---- rtl/sarc_pkg.sv ----
// Shared constants and types of the converter serial readout and power control.
`default_nettype none
package sarc_pkg;

  // ********************************************************************
  // Frame counts, in falling serial clock edges or in bits
  // ********************************************************************
  localparam logic [4:0] FRAME_FALLS      = 5'h10;
  localparam logic [4:0] GLITCH_FALLS     = 5'h02;
  localparam logic [4:0] KEEP_POWER_FALLS = 5'h0a;
  localparam int         LEAD_ZEROS       = 2;
  localparam int         FRAME_BITS       = 16;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic       SYNC_IDLE_LEVEL = 1'b1;
  localparam logic [4:0] FALL_CNT_RESET  = 5'h00;

  // ********************************************************************
  // Power states and frame states
  // ********************************************************************
  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_PARTIAL = 2'b01,
    PWR_FULL    = 2'b10
  } sarc_pwr_t;

  typedef enum logic {
    FRAME_IDLE   = 1'b0,
    FRAME_ACTIVE = 1'b1
  } sarc_frame_t;

endpackage
`default_nettype wire

// ---- rtl/sarc_sync.sv ----
// Two flip-flop synchroniser for one pin sampled by the block clock.
`timescale 1ns/1ps
`default_nettype none
module sarc_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output var  logic pin_sync
);

  logic stage_a;
  logic next_stage_a;
  logic next_pin_sync;

  // Only the second stage reads the first one.
  always_comb begin
    next_stage_a  = pin_in;
    next_pin_sync = stage_a;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage_a  <= RESET_LEVEL;
      pin_sync <= RESET_LEVEL;
    end else begin
      stage_a  <= next_stage_a;
      pin_sync <= next_pin_sync;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/sarc_readout.sv ----
// Serial readout and power-state control of the successive-approximation converter.
//
// Overview of operation
// RULE_01 - After one full dummy frame from partial power-down the device is powered normal.
// RULE_02 - Host waits the quiet interval after tri-state before the next select fall.
// RULE_03 - Host allows about 1 us after select falls when waking from full power-down.
// RULE_04 - Waking from partial power-down, hold until the first clock edge, then track.
// RULE_05 - Host runs one dummy frame after supply application before trusting results.
// RULE_06 - Host reaches partial power-down after power-on with two dummy frames.
// RULE_07 - Host reaches full power-down after power-on with three dummy frames.
// RULE_08 - Select fall holds the sample, drives the output and starts conversion.
// RULE_09 - 12-bit: 14 cycles convert; track resumes on rising edge after 13 falls.
// RULE_10 - 12-bit: select rising before 14 clocks aborts and tri-states the output.
// RULE_11 - 12-bit: two trailing zeros, output released on the 16th falling edge.
// RULE_12 - 10-bit: 12 cycles, track after 11 falls, early select rise aborts.
// RULE_13 - 10-bit: four trailing zeros, output released on the 16th falling edge.
// RULE_14 - 8-bit: 10 cycles, track after 9 falls, early select rise powers down.
// RULE_15 - 8-bit: six trailing zeros, output released on the 16th falling edge.
// RULE_16 - Host in 14-clock frames raises select after the 14th falling edge.
// RULE_17 - Select fall gives first leading zero; each clock fall shifts the next bit.
// RULE_18 - Slow-clock host may sample on rising edges and miss the first zero.
// RULE_19 - Select falling just after a clock fall lets host read both zeros on rises.
// RULE_20 - 8-bit 10-clock frame ends at the 10th rising edge in normal mode.
// RULE_21 - Host keeps acquisition at least 60 ns and quiet gap at least 4 ns.
// RULE_22 - Select rising between 2nd and 10th fall aborts and enters partial power-down.
// RULE_23 - Select rising before the 2nd fall keeps normal mode for glitch immunity.
// RULE_24 - In partial power-down, select rising before the 10th fall enters full power-down.
// RULE_25 - Host holds select low for at least 10 falls to keep normal mode.
// RULE_26 - Result width parameter sets conversion cycles and trailing zero count.
`timescale 1ns/1ps
`default_nettype none
module sarc_readout #(
  parameter int RESULT_BITS = 12
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic [RESULT_BITS-1:0] sample_data,
  output var  logic                   serial_result_out,
  output var  logic                   serial_result_oe,
  output var  logic                   track_mode,
  output var  sarc_pkg::sarc_pwr_t    power_state
);

  // ********************************************************************
  // Variant-dependent counts and the fixed last fall
  // ********************************************************************
  localparam logic [4:0] CONV_CYCLES = 5'(RESULT_BITS + sarc_pkg::LEAD_ZEROS); // [RULE_26]
  localparam logic [4:0] TRACK_FALLS = 5'(RESULT_BITS + sarc_pkg::LEAD_ZEROS - 1);
  localparam int         TRAIL_BITS  = sarc_pkg::FRAME_BITS - sarc_pkg::LEAD_ZEROS - RESULT_BITS;
  localparam logic [4:0] LAST_FALL   = 5'(sarc_pkg::FRAME_FALLS - 5'h01);

  // ********************************************************************
  // Pin synchronisation and edge detection
  // ********************************************************************
  logic cs_sync;
  logic sclk_sync;
  logic cs_prev;
  logic sclk_prev;
  logic next_cs_prev;
  logic next_sclk_prev;

  sarc_sync #(.RESET_LEVEL(sarc_pkg::SYNC_IDLE_LEVEL)) u_cs_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pin_in   (cs_n),
    .pin_sync (cs_sync)
  );

  sarc_sync #(.RESET_LEVEL(sarc_pkg::SYNC_IDLE_LEVEL)) u_sclk_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pin_in   (sclk),
    .pin_sync (sclk_sync)
  );

  always_comb begin
    next_cs_prev   = cs_sync;
    next_sclk_prev = sclk_sync;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_prev   <= sarc_pkg::SYNC_IDLE_LEVEL;
      sclk_prev <= sarc_pkg::SYNC_IDLE_LEVEL;
    end else begin
      cs_prev   <= next_cs_prev;
      sclk_prev <= next_sclk_prev;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  assign cs_fall   = cs_prev & ~cs_sync;
  assign cs_rise   = ~cs_prev & cs_sync;
  assign sclk_fall = sclk_prev & ~sclk_sync;
  assign sclk_rise = ~sclk_prev & sclk_sync;

  // ********************************************************************
  // Frame, shift and power state
  // ********************************************************************
  sarc_pkg::sarc_frame_t frame;
  sarc_pkg::sarc_frame_t next_frame;
  sarc_pkg::sarc_pwr_t   next_power_state;
  logic [4:0]            fall_cnt;
  logic [4:0]            next_fall_cnt;
  logic [15:0]           shift_reg;
  logic [15:0]           next_shift_reg;
  logic                  edge_seen;
  logic                  next_edge_seen;
  logic                  next_out;
  logic                  next_oe;
  logic                  next_track;

  always_comb begin
    next_frame       = frame;
    next_power_state = power_state;
    next_fall_cnt    = fall_cnt;
    next_shift_reg   = shift_reg;
    next_edge_seen   = edge_seen;
    next_out         = serial_result_out;
    next_oe          = serial_result_oe;
    next_track       = track_mode;
    case (frame)
      sarc_pkg::FRAME_IDLE: begin
        if (cs_fall) begin
          // Sample is frozen here; the first leading zero leaves at once.
          next_frame     = sarc_pkg::FRAME_ACTIVE; // [RULE_08]
          next_track     = 1'b0; // [RULE_08]
          next_oe        = 1'b1; // [RULE_08]
          next_out       = 1'b0; // [RULE_17]
          next_shift_reg = {2'b00, sample_data, {TRAIL_BITS{1'b0}}}; // [RULE_11] [RULE_13] [RULE_15]
          next_fall_cnt  = sarc_pkg::FALL_CNT_RESET;
          next_edge_seen = 1'b0;
        end
      end
      sarc_pkg::FRAME_ACTIVE: begin
        if (cs_rise) begin
          // Any early rise aborts; the fall count and the current power state decide the next power state.
          next_frame = sarc_pkg::FRAME_IDLE;
          next_oe    = 1'b0; // [RULE_10] [RULE_12]
          next_out   = 1'b0;
          if (fall_cnt >= sarc_pkg::KEEP_POWER_FALLS) begin
            next_power_state = sarc_pkg::PWR_NORMAL; // [RULE_01] [RULE_20]
          end else if (power_state != sarc_pkg::PWR_NORMAL) begin
            next_power_state = sarc_pkg::PWR_FULL; // [RULE_24]
          end else if (fall_cnt >= sarc_pkg::GLITCH_FALLS) begin
            next_power_state = sarc_pkg::PWR_PARTIAL; // [RULE_22] [RULE_14]
          end else begin
            next_power_state = sarc_pkg::PWR_NORMAL; // [RULE_23]
          end
          next_track = (next_power_state == sarc_pkg::PWR_NORMAL);
        end else begin
          if (sclk_fall || sclk_rise) begin
            next_edge_seen = 1'b1;
            if (!edge_seen && power_state == sarc_pkg::PWR_PARTIAL) begin
              next_track = 1'b1; // [RULE_04]
            end
          end
          if (sclk_rise && fall_cnt == TRACK_FALLS) begin
            next_track = 1'b1; // [RULE_09] [RULE_12] [RULE_14] [RULE_20]
          end
          if (sclk_fall && fall_cnt < sarc_pkg::FRAME_FALLS) begin
            next_fall_cnt  = fall_cnt + 5'h01;
            next_shift_reg = {shift_reg[14:0], 1'b0};
            next_out       = shift_reg[14]; // [RULE_17]
            if (fall_cnt == LAST_FALL) begin
              next_oe  = 1'b0; // [RULE_11] [RULE_13] [RULE_15]
              next_out = 1'b0;
            end
          end
        end
      end
      default: begin
        next_frame = sarc_pkg::FRAME_IDLE;
        next_oe    = 1'b0;
      end
    endcase
  end

  // The analog power-up is not modelled; reset starts the device in normal mode.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame             <= sarc_pkg::FRAME_IDLE;
      power_state       <= sarc_pkg::PWR_NORMAL;
      fall_cnt          <= sarc_pkg::FALL_CNT_RESET;
      shift_reg         <= 16'h0000;
      edge_seen         <= 1'b0;
      serial_result_out <= 1'b0;
      serial_result_oe  <= 1'b0;
      track_mode        <= 1'b1;
    end else begin
      frame             <= next_frame;
      power_state       <= next_power_state;
      fall_cnt          <= next_fall_cnt;
      shift_reg         <= next_shift_reg;
      edge_seen         <= next_edge_seen;
      serial_result_out <= next_out;
      serial_result_oe  <= next_oe;
      track_mode        <= next_track;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  a_fall_starts_frame: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_08]
    (cs_fall && frame == sarc_pkg::FRAME_IDLE) |=> (serial_result_oe && !serial_result_out && !track_mode))
    else $error("select fall did not start a frame");

  a_release_on_last: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_11]
    (frame == sarc_pkg::FRAME_ACTIVE && !cs_rise && sclk_fall && fall_cnt == LAST_FALL)
    |=> (!serial_result_oe && fall_cnt == sarc_pkg::FRAME_FALLS))
    else $error("output not released on last falling edge");

  a_rise_aborts: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_10]
    (frame == sarc_pkg::FRAME_ACTIVE && cs_rise) |=> (!serial_result_oe && frame == sarc_pkg::FRAME_IDLE))
    else $error("select rise did not tri-state the output");

  a_glitch_keeps_normal: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_23]
    (frame == sarc_pkg::FRAME_ACTIVE && cs_rise && power_state == sarc_pkg::PWR_NORMAL
     && fall_cnt < sarc_pkg::GLITCH_FALLS) |=> (power_state == sarc_pkg::PWR_NORMAL && track_mode))
    else $error("early select rise left normal mode");

  a_partial_entry: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_22]
    (frame == sarc_pkg::FRAME_ACTIVE && cs_rise && power_state == sarc_pkg::PWR_NORMAL
     && fall_cnt >= sarc_pkg::GLITCH_FALLS && fall_cnt < sarc_pkg::KEEP_POWER_FALLS)
    |=> (power_state == sarc_pkg::PWR_PARTIAL && !track_mode))
    else $error("partial power-down not entered");

  a_full_entry: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_24]
    (frame == sarc_pkg::FRAME_ACTIVE && cs_rise && power_state == sarc_pkg::PWR_PARTIAL
     && fall_cnt < sarc_pkg::KEEP_POWER_FALLS) |=> (power_state == sarc_pkg::PWR_FULL))
    else $error("full power-down not entered");

  a_dummy_wakes: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_01]
    (frame == sarc_pkg::FRAME_ACTIVE && cs_rise && fall_cnt >= sarc_pkg::KEEP_POWER_FALLS)
    |=> (power_state == sarc_pkg::PWR_NORMAL) [*2])
    else $error("dummy frame did not power the device up");

  a_track_return: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_09]
    (frame == sarc_pkg::FRAME_ACTIVE && !cs_rise && sclk_rise && fall_cnt == TRACK_FALLS) |=> track_mode)
    else $error("track not resumed after conversion");

  a_wake_track: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_04]
    (frame == sarc_pkg::FRAME_ACTIVE && !cs_rise && power_state == sarc_pkg::PWR_PARTIAL
     && !edge_seen && (sclk_rise || sclk_fall)) |=> track_mode)
    else $error("partial wake did not switch to track");

  a_shift_next_bit: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_17]
    (frame == sarc_pkg::FRAME_ACTIVE && !cs_rise && sclk_fall && fall_cnt < LAST_FALL)
    |=> (serial_result_out == $past(shift_reg[14]) && serial_result_oe))
    else $error("serial bit not shifted on falling edge");

  a_trailing_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE_13]
    (serial_result_oe && fall_cnt >= CONV_CYCLES) |-> !serial_result_out)
    else $error("trailing bit not zero");

endmodule
`default_nettype wire

// ---- tb/sarc_host_model.sv ----
// Host model that drives select and serial clock and reads the data line.
`timescale 1ns/1ps
`default_nettype none
module sarc_host_model (
  input  wire logic ref_clk,
  input  wire logic serial_result_out,
  input  wire logic serial_result_oe,
  input  wire logic track_mode,
  input  wire logic alt_result_out,
  input  wire logic alt_result_oe,
  input  wire logic alt_track_mode,
  output var  logic cs_n,
  output var  logic sclk
);
  // ******************************************************************
  // Frame driver
  // ******************************************************************
  localparam int HALF = 8;
  logic        last_bit;
  logic        data_line;
  logic        oe_after;
  logic [15:0] word;
  logic [15:0] oe_seen;
  logic [15:0] track_seen;
  logic [15:0] alt_word;
  logic [15:0] alt_oe_seen;
  logic [15:0] alt_track_seen;

  // A released line keeps no level, so the model reads the inverse of the last bit.
  assign data_line = serial_result_oe ? serial_result_out : ~last_bit;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    last_bit = 1'b0;
  end

  always @(posedge ref_clk) begin
    if (serial_result_oe) last_bit <= serial_result_out;
  end

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // The sample point sits half a clock period after each rise, so bit k is read after fall k.
  // With rise_read set the clock idles low, select falls just after a clock fall and bits are read on rises.
  task automatic run_frame(input int n, input int wake_wait, input logic rise_read);
    word = 16'h0000;
    oe_seen = 16'h0000;
    track_seen = 16'h0000;
    alt_word = 16'h0000;
    alt_oe_seen = 16'h0000;
    alt_track_seen = 16'h0000;
    @(negedge ref_clk);
    sclk = ~rise_read;
    @(negedge ref_clk);
    cs_n = 1'b0;
    wait_cycles(wake_wait);
    wait_cycles(HALF);
    for (int k = 0; k < n; k++) begin
      word[15-k] = data_line;
      oe_seen[15-k] = serial_result_oe;
      track_seen[15-k] = track_mode;
      alt_word[15-k] = alt_result_out;
      alt_oe_seen[15-k] = alt_result_oe;
      alt_track_seen[15-k] = alt_track_mode;
      sclk = rise_read;
      wait_cycles(HALF);
      sclk = ~rise_read;
      wait_cycles(HALF);
    end
    oe_after = serial_result_oe;
    cs_n = 1'b1;
    wait_cycles(HALF);
  endtask
endmodule
`default_nettype wire

// ---- tb/sar_adc_serial_readout_power_ctrl_bench.sv ----
// Self-checking bench of the converter serial readout and power control.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_power_ctrl_bench;
  // ******************************************************************
  // Signals and instances
  // ******************************************************************
  localparam int RB    = 12;
  localparam int LIMIT = 20000;
  logic                ref_clk;
  logic                rst_n;
  logic                sclk;
  logic                cs_n;
  logic                out;
  logic                oe;
  logic                track;
  logic [RB-1:0]       sample_data;
  sarc_pkg::sarc_pwr_t power_state;
  logic                out_8;
  logic                oe_8;
  logic                track_8;
  sarc_pkg::sarc_pwr_t power_state_8;
  int                  num_errors;
  int                  n_checks;
  int                  cycles = 0;

  sarc_readout #(.RESULT_BITS(RB)) uut (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .sclk              (sclk),
    .cs_n              (cs_n),
    .sample_data       (sample_data),
    .serial_result_out (out),
    .serial_result_oe  (oe),
    .track_mode        (track),
    .power_state       (power_state)
  );

  // The 8-bit variant shares the pins and takes the upper result bits.
  sarc_readout #(.RESULT_BITS(8)) uut_8 (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .sclk              (sclk),
    .cs_n              (cs_n),
    .sample_data       (sample_data[11:4]),
    .serial_result_out (out_8),
    .serial_result_oe  (oe_8),
    .track_mode        (track_8),
    .power_state       (power_state_8)
  );

  sarc_host_model host (
    .ref_clk           (ref_clk),
    .serial_result_out (out),
    .serial_result_oe  (oe),
    .track_mode        (track),
    .alt_result_out    (out_8),
    .alt_result_oe     (oe_8),
    .alt_track_mode    (track_8),
    .cs_n              (cs_n),
    .sclk              (sclk)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ******************************************************************
  // Checking and closing
  // ******************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      print_verdict();
    end
  end

  // Runs one frame of n falls (n at most 16) and judges what the host saw from both variants.
  task automatic frame(input int n, input int wake, input logic rise, input logic [15:0] trk,
                       input logic [15:0] trk8, input sarc_pkg::sarc_pwr_t pwr);
    logic [15:0] mask;
    mask = 16'hffff << (16 - n);
    host.run_frame(n, wake, rise);
    check("data word", host.word, {2'b00, sample_data, 2'b00} & mask);
    check("data word 8-bit", host.alt_word, {2'b00, sample_data[11:4], 6'h00} & mask);
    check("drive enable", host.oe_seen, mask);
    check("drive enable 8-bit", host.alt_oe_seen, mask);
    check("track pattern", host.track_seen, trk);
    check("track pattern 8-bit", host.alt_track_seen, trk8);
    check("enable at frame end", {15'h0000, host.oe_after}, {15'h0000, n < 16});
    check("power state", {14'h0000, power_state}, {14'h0000, pwr});
    check("power state 8-bit", {14'h0000, power_state_8}, {14'h0000, pwr});
    check("enable after select rise", {14'h0000, oe, oe_8}, 16'h0000);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_full_frames();
    sample_data = 12'ha5c;
    frame(16, 0, 1'b0, 16'h0007, 16'h007f, sarc_pkg::PWR_NORMAL);
    sample_data = 12'h801;
    frame(16, 0, 1'b0, 16'h0007, 16'h007f, sarc_pkg::PWR_NORMAL);
    frame(16, 0, 1'b1, 16'h0003, 16'h003f, sarc_pkg::PWR_NORMAL);
  endtask

  task automatic t_short_frames();
    sample_data = 12'h3c1;
    frame(14, 0, 1'b0, 16'h0004, 16'h007c, sarc_pkg::PWR_NORMAL);
    frame(12, 0, 1'b0, 16'h0000, 16'h0070, sarc_pkg::PWR_NORMAL);
    frame(10, 0, 1'b0, 16'h0000, 16'h0040, sarc_pkg::PWR_NORMAL);
  endtask

  task automatic t_glitch();
    frame(1, 0, 1'b0, 16'h0000, 16'h0000, sarc_pkg::PWR_NORMAL);
  endtask

  task automatic t_partial_wake();
    sample_data = 12'hfff;
    frame(5, 0, 1'b0, 16'h0000, 16'h0000, sarc_pkg::PWR_PARTIAL);
    frame(16, 0, 1'b0, 16'h7fff, 16'h7fff, sarc_pkg::PWR_NORMAL);
    frame(16, 0, 1'b0, 16'h0007, 16'h007f, sarc_pkg::PWR_NORMAL);
  endtask

  task automatic t_full_wake();
    sample_data = 12'h5a3;
    frame(2, 0, 1'b0, 16'h0000, 16'h0000, sarc_pkg::PWR_PARTIAL);
    frame(5, 0, 1'b0, 16'h7800, 16'h7800, sarc_pkg::PWR_FULL);
    frame(16, 100, 1'b0, 16'h0007, 16'h007f, sarc_pkg::PWR_NORMAL);
    frame(16, 0, 1'b0, 16'h0007, 16'h007f, sarc_pkg::PWR_NORMAL);
  endtask

  initial begin
    rst_n = 1'b0;
    sample_data = 12'h000;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(negedge ref_clk);
    check("reset state", {12'h000, oe, track, power_state}, 16'h0004);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_full_frames();
    t_short_frames();
    t_glitch();
    t_partial_wake();
    t_full_wake();
    print_verdict();
  end
endmodule
`default_nettype wire
